// *** design/vlan_qos_pkg.sv ***
// vlan tagging and qos queueing: shared constants, types and functions
// assumes byte-wide frames with fcs and 8-bit registers on a 32-bit apb
package vlan_qos_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL = 8'h53;
  localparam logic [7:0] IDX_QOS_EN = 8'h54;
  localparam logic [7:0] IDX_STATUS = 8'h56;
  localparam logic [7:0] IDX_QLEVEL = 8'h57;
  localparam logic [7:0] IDX_PORT_CTL = 8'h6d;
  localparam logic [7:0] IDX_PORT_DEFAULT_VLAN_ID = 8'h6f;
  localparam logic [7:0] IDX_TOS_MAP = 8'hc0;
  localparam logic [7:0] IDX_TAG_MAP = 8'hd0;
  // field positions
  localparam int BIT_TAG_PORT = 7;
  localparam int BIT_SPQ = 5;
  localparam int BIT_TAGPRI_DIS = 2;
  localparam int BIT_TOS3 = 7;
  localparam int BIT_DOT1Q = 1;
  localparam int BIT_TOS_EN = 0;
  // reset values
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_QOS_EN = 8'h00;
  localparam logic [7:0] RST_PORT_CTL = 8'h00;
  localparam logic [7:0] RST_PORT_DEFAULT_VLAN_ID = 8'h01;
  localparam logic [7:0] RST_TOS_MAP = 8'h00;
  localparam logic [7:0] RST_TAG_MAP0 = 8'h50;
  localparam logic [7:0] RST_TAG_MAP1 = 8'hfa;
  // frame layout
  localparam logic [15:0] TPID = 16'h8100;
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [10:0] POS_HDR_END = 11'd11;
  localparam logic [10:0] POS_TYPE_LO = 11'd13;
  localparam logic [10:0] POS_PCP = 11'd14;
  localparam logic [10:0] POS_TOS_UNTAG = 11'd15;
  localparam logic [10:0] POS_TAG_END = 11'd15;
  localparam logic [10:0] POS_INNER_HI = 11'd16;
  localparam logic [10:0] POS_INNER_LO = 11'd17;
  localparam logic [10:0] POS_TOS_TAG = 11'd19;
  // weighted round-robin credits, queue 3 served most
  localparam logic [3:0] WRR_WEIGHT [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam int HANDLE_W = 8;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] dst;
    logic [HANDLE_W-1:0] handle;
  } frame_meta_t;

  typedef struct packed {
    logic [1:0] queue;
    logic [HANDLE_W-1:0] handle;
  } queue_token_t;

  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction
endpackage

// *** design/frame_fcs_tail.sv ***
// frame fcs tail: holds back four bytes, replaces the fcs when asked
// assumes every frame carries a 4-byte fcs and is longer than 4 bytes
`timescale 1ns/1ps
module frame_fcs_tail import vlan_qos_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // edited stream in
  input wire logic s_valid,
  input wire logic [7:0] s_data,
  input wire logic s_last,
  input wire logic s_regen,
  output logic s_ready,
  // stream out
  output logic m_valid,
  output logic [7:0] m_data,
  output logic m_last,
  input wire logic m_ready
);
  logic [7:0] sh_r [4];
  logic [2:0] fill_r;
  logic drain_r;
  logic regen_r;
  logic [1:0] k_r;
  logic [31:0] crc_r;
  logic [31:0] fsh;
  logic full, take, give;

  assign full = fill_r == 3'd4;
  // no new bytes while the old fcs drains
  assign s_ready = !drain_r && (!full || m_ready);
  assign m_valid = drain_r || (s_valid && full);
  assign m_last = drain_r && k_r == 2'd3;
  assign take = s_valid && s_ready;
  assign give = m_valid && m_ready;
  assign fsh = ~crc_r >> {k_r, 3'b000};
  assign m_data = (drain_r && regen_r) ? fsh[7:0] : sh_r[3];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      for (int i = 0; i < 4; i++)
        sh_r[i] <= 8'h00;
    else if (take || (drain_r && give))
    begin
      sh_r[3] <= sh_r[2];
      sh_r[2] <= sh_r[1];
      sh_r[1] <= sh_r[0];
      sh_r[0] <= s_data;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fill_r <= 3'd0;
      drain_r <= 1'b0;
      regen_r <= 1'b0;
      k_r <= 2'd0;
    end
    else if (drain_r)
    begin
      if (give)
        k_r <= k_r + 2'd1;
      if (give && k_r == 2'd3)
      begin
        drain_r <= 1'b0;
        fill_r <= 3'd0;
      end
    end
    else if (take)
    begin
      if (!full)
        fill_r <= fill_r + 3'd1;
      if (s_last)
      begin
        drain_r <= 1'b1;
        regen_r <= s_regen;
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      crc_r <= CRC_INIT;
    else if (drain_r && give && k_r == 2'd3)
      crc_r <= CRC_INIT;
    else if (take && full)
      crc_r <= crc_byte(crc_r, sh_r[3]);
endmodule

// *** design/port_tx_queues.sv ***
// four transmit queues of frame handles for one egress port
// assumes the mac takes one handle per frame when it is ready
`timescale 1ns/1ps
module port_tx_queues import vlan_qos_pkg::*; #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // enqueue from the tagging stage
  input wire logic enq_valid,
  input wire queue_token_t enq_token,
  output logic [3:0] full,
  // dequeue toward the mac
  input wire logic mode_spq,
  input wire logic deq_ready,
  output logic deq_valid,
  output queue_token_t deq_token,
  output logic [3:0] nonempty
);
  localparam int AW = $clog2(DEPTH);
  logic [HANDLE_W-1:0] head [4];
  logic [1:0] cur_r, sel;
  logic [3:0] credit_r;
  logic deq;

  function automatic logic [1:0] highest(logic [3:0] ne);
    logic [1:0] h;
    h = 2'd0;
    for (int i = 0; i < 4; i++)
      if (ne[i])
        h = 2'(i);
    return h;
  endfunction

  function automatic logic [1:0] next_rr(logic [1:0] c, logic [3:0] ne);
    logic [1:0] n;
    n = c;
    for (int i = 3; i >= 1; i--)
      if (ne[2'(c - 2'(i))])
        n = 2'(c - 2'(i));
    return n;
  endfunction

  always_comb
    if (mode_spq)
      sel = highest(nonempty);
    else if (nonempty[cur_r] && credit_r != 4'h0)
      sel = cur_r;
    else
      sel = next_rr(cur_r, nonempty);

  assign deq_valid = |nonempty;
  assign deq = deq_valid && deq_ready;
  assign deq_token = '{queue: sel, handle: head[sel]};

  for (genvar q = 0; q < 4; q++)
  begin : g_q
    logic [HANDLE_W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r, rd_r;
    logic [AW:0] cnt_r;
    logic push, pop;
    assign push = enq_valid && enq_token.queue == 2'(q) && !full[q];
    assign pop = deq && sel == 2'(q);
    assign full[q] = cnt_r == (AW+1)'(DEPTH);
    assign nonempty[q] = cnt_r != '0;
    assign head[q] = mem[rd_r];
    always_ff @(posedge pclk)
      if (push)
        mem[wr_r] <= enq_token.handle;
    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
        wr_r <= '0;
        rd_r <= '0;
        cnt_r <= '0;
      end
      else
      begin
        if (push)
          wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
        if (pop)
          rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
        cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
  end

  // credits give each queue turns in proportion to its weight
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cur_r <= 2'd3;
      credit_r <= WRR_WEIGHT[3];
    end
    else if (deq && !mode_spq)
    begin
      cur_r <= sel;
      credit_r <= (sel != cur_r || credit_r == 4'h0) ? WRR_WEIGHT[sel] - 4'h1
                                 : credit_r - 4'h1;
    end
endmodule

// *** design/vlan_qos_egress.sv ***
// egress tag edit, priority classification and queueing, apb registers
// assumes the forwarding engine streams one frame at a time with fcs,
// and meta (source, destination, buffer handle) valid on the first byte
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module vlan_qos_egress import vlan_qos_pkg::*; #(
  parameter int NPORTS = 3,
  parameter int QDEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame stream from the forwarding engine
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire frame_meta_t in_meta,
  output logic in_ready,
  // edited frame stream to the buffer
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  output logic [1:0] out_port,
  input wire logic out_ready,
  // per-port handle hand-off to the transmit macs
  input wire logic [NPORTS-1:0] tx_ready,
  output logic [NPORTS-1:0] tx_valid,
  output queue_token_t tx_token [NPORTS]
);
  typedef enum logic [1:0] {S_PASS, S_CAP, S_EMIT, S_DROP} edit_state_t;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] global_r, qos_en_r;
  logic [7:0] port_ctl_r [NPORTS];
  logic [7:0] port_default_vlan_id_r [NPORTS];
  logic [7:0] tos_map_r [16];
  logic [7:0] tag_map_r [2];
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [7:0] idx;
  logic [1:0] pnum;
  logic [7:0] rd_val;
  logic addr_ok, port_ok, wr_en;
  logic [1:0] last_q_r;
  logic busy;
  logic [3:0] q_full [NPORTS];
  logic [3:0] q_ne [NPORTS];

  function automatic logic in_range(logic [7:0] i, logic [7:0] base,
                                    int n);
    return i >= base && int'(i - base) < n;
  endfunction

  function automatic logic [1:0] map2(logic [7:0] v, logic [1:0] slot);
    logic [7:0] s;
    s = v >> {slot, 1'b0};
    return s[1:0];
  endfunction

  assign idx = paddr[9:2];
  assign pnum = paddr[11:10];
  assign port_ok = int'(pnum) < NPORTS;

  always_comb
  begin
    rd_val = 8'h00;
    addr_ok = port_ok;
    if (idx == IDX_GLOBAL)
      rd_val = global_r;
    else if (idx == IDX_QOS_EN)
      rd_val = qos_en_r;
    else if (idx == IDX_STATUS)
      rd_val = {5'b00000, last_q_r, busy};
    else if (idx == IDX_QLEVEL && port_ok)
      rd_val = {4'h0, q_ne[pnum]};
    else if (idx == IDX_PORT_CTL && port_ok)
      rd_val = port_ctl_r[pnum];
    else if (idx == IDX_PORT_DEFAULT_VLAN_ID && port_ok)
      rd_val = port_default_vlan_id_r[pnum];
    else if (in_range(idx, IDX_TOS_MAP, 16))
      rd_val = tos_map_r[idx[3:0]];
    else if (in_range(idx, IDX_TAG_MAP, 2))
      rd_val = tag_map_r[idx[0]];
    else
      addr_ok = 1'b0;
  end

  // one wait state so read data leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else if (psel && penable && !pready_r)
    begin
      pready_r <= 1'b1;
      pslverr_r <= !addr_ok;
      prdata_r <= (pwrite || !addr_ok) ? 32'h00000000 : {24'h000000, rd_val};
    end
    else
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign wr_en = psel && penable && pready_r && pwrite && addr_ok
                 && pstrb[0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      global_r <= RST_GLOBAL;
      qos_en_r <= RST_QOS_EN;
      for (int p = 0; p < NPORTS; p++)
      begin
        port_ctl_r[p] <= RST_PORT_CTL;
        port_default_vlan_id_r[p] <= RST_PORT_DEFAULT_VLAN_ID;
      end
      for (int i = 0; i < 16; i++)
        tos_map_r[i] <= RST_TOS_MAP;
      tag_map_r[0] <= RST_TAG_MAP0;
      tag_map_r[1] <= RST_TAG_MAP1;
    end
    else if (wr_en)
    begin
      if (idx == IDX_GLOBAL)
        global_r <= pwdata[7:0];
      else if (idx == IDX_QOS_EN)
        qos_en_r <= pwdata[7:0];
      else if (idx == IDX_PORT_CTL)
        port_ctl_r[pnum] <= pwdata[7:0];
      else if (idx == IDX_PORT_DEFAULT_VLAN_ID)
        port_default_vlan_id_r[pnum] <= pwdata[7:0];
      else if (in_range(idx, IDX_TOS_MAP, 16))
        tos_map_r[idx[3:0]] <= pwdata[7:0];
      else if (in_range(idx, IDX_TAG_MAP, 2))
        tag_map_r[idx[0]] <= pwdata[7:0];
    end

  ////////////////////////////////////////////////////////////////////////
  // tag edit
  edit_state_t state_r;
  logic [10:0] cnt_r;
  logic [2:0] k_r;
  frame_meta_t meta_r;
  logic [7:0] th_r, ih_r, tos_r;
  logic [2:0] pcp_r;
  logic tagged_r, ipv4_r, regen_r;
  logic e_valid, e_ready, e_last, accept, fin, stall_q;
  logic [7:0] e_data;
  logic [15:0] tci;
  logic [1:0] qsel;
  logic [5:0] tos_idx;
  logic [7:0] src_ctl, dst_ctl;
  logic is_tag_now, vlan_mode, dst_tags;

  assign src_ctl = port_ctl_r[meta_r.src];
  assign dst_ctl = port_ctl_r[meta_r.dst];
  assign vlan_mode = global_r[BIT_DOT1Q];
  assign dst_tags = dst_ctl[BIT_TAG_PORT];
  assign is_tag_now = {th_r, in_data} == TPID;
  assign tci = {8'h00, port_default_vlan_id_r[meta_r.src]};

  // queue choice, tos first, then tag priority, then port default
  always_comb
  begin
    tos_idx = global_r[BIT_TOS3] ? {3'b000, tos_r[7:5]}
                                 : tos_r[7:2];
    if (qos_en_r[BIT_TOS_EN] && ipv4_r)
      qsel = map2(tos_map_r[tos_idx[5:2]], tos_idx[1:0]);
    else if (tagged_r && !src_ctl[BIT_TAGPRI_DIS])
      qsel = map2(tag_map_r[pcp_r[2]], pcp_r[1:0]);
    else
      qsel = src_ctl[1:0];
  end

  // hold the last byte until its queue has room
  assign stall_q = in_last && q_full[meta_r.dst][qsel];

  always_comb
  begin
    e_valid = 1'b0;
    e_data = in_data;
    e_last = 1'b0;
    in_ready = 1'b0;
    case (state_r)
      S_PASS:
      begin
        e_valid = in_valid && !stall_q;
        e_last = in_last;
        in_ready = e_ready && !stall_q;
      end
      S_CAP, S_DROP:
        in_ready = 1'b1;
      S_EMIT:
      begin
        e_valid = 1'b1;
        case (k_r)
          3'd0: e_data = TPID[15:8];
          3'd1: e_data = TPID[7:0];
          3'd2: e_data = tci[15:8];
          3'd3: e_data = tci[7:0];
          3'd4: e_data = th_r;
          default: e_data = ih_r;
        endcase
      end
      default:
        in_ready = 1'b0;
    endcase
  end

  assign accept = in_valid && in_ready;
  assign fin = accept && in_last && state_r == S_PASS;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_r <= S_PASS;
      cnt_r <= 11'd0;
      k_r <= 3'd0;
      regen_r <= 1'b0;
    end
    else
      case (state_r)
        S_PASS:
          if (accept)
          begin
            cnt_r <= in_last ? 11'd0 : cnt_r + 11'd1;
            if (!in_last && cnt_r == POS_HDR_END)
              state_r <= S_CAP;
            if (cnt_r == 11'd0)
              regen_r <= 1'b0;
          end
        S_CAP:
          if (accept)
          begin
            cnt_r <= cnt_r + 11'd1;
            if (cnt_r == POS_TYPE_LO)
            begin
              if (vlan_mode && is_tag_now && !dst_tags)
              begin
                state_r <= S_DROP;
                regen_r <= 1'b1;
              end
              else if (vlan_mode && !is_tag_now && dst_tags)
              begin
                state_r <= S_EMIT;
                k_r <= 3'd0;
                regen_r <= 1'b1;
              end
              else
              begin
                state_r <= S_EMIT;
                k_r <= 3'd4;
              end
            end
          end
        S_EMIT:
          if (e_ready)
          begin
            k_r <= k_r + 3'd1;
            if (k_r == 3'd5)
              state_r <= S_PASS;
          end
        S_DROP:
          if (accept)
          begin
            cnt_r <= cnt_r + 11'd1;
            if (cnt_r == POS_TAG_END)
              state_r <= S_PASS;
          end
        default:
          state_r <= S_PASS;
      endcase

  // header fields for classification
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      meta_r <= '0;
      th_r <= 8'h00;
      ih_r <= 8'h00;
      tos_r <= 8'h00;
      pcp_r <= 3'd0;
      tagged_r <= 1'b0;
      ipv4_r <= 1'b0;
    end
    else if (accept)
    begin
      if (cnt_r == 11'd0)
        meta_r <= in_meta;
      if (cnt_r == POS_TYPE_LO - 11'd1)
        th_r <= in_data;
      if (cnt_r == POS_TYPE_LO)
      begin
        ih_r <= in_data;
        tagged_r <= is_tag_now;
        ipv4_r <= {th_r, in_data} == ETYPE_IPV4;
      end
      if (tagged_r && cnt_r == POS_PCP)
        pcp_r <= in_data[7:5];
      if (tagged_r && cnt_r == POS_INNER_HI)
        tos_r <= in_data;
      if (tagged_r && cnt_r == POS_INNER_LO)
        ipv4_r <= {tos_r, in_data} == ETYPE_IPV4;
      if (cnt_r == (tagged_r ? POS_TOS_TAG : POS_TOS_UNTAG))
        tos_r <= in_data;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      last_q_r <= 2'd0;
    else if (fin)
      last_q_r <= qsel;

  assign busy = state_r != S_PASS || cnt_r != 11'd0;

  frame_fcs_tail u_fcs (
    .pclk(pclk),
    .presetn(presetn),
    .s_valid(e_valid),
    .s_data(e_data),
    .s_last(e_last),
    .s_regen(regen_r),
    .s_ready(e_ready),
    .m_valid(out_valid),
    .m_data(out_data),
    .m_last(out_last),
    .m_ready(out_ready)
  );
  assign out_port = meta_r.dst;

  ////////////////////////////////////////////////////////////////////////
  // per-port queues and scheduling
  for (genvar p = 0; p < NPORTS; p++)
  begin : g_port
    port_tx_queues #(.DEPTH(QDEPTH)) u_q (
      .pclk(pclk),
      .presetn(presetn),
      .enq_valid(fin && meta_r.dst == 2'(p)),
      .enq_token('{queue: qsel, handle: meta_r.handle}),
      .full(q_full[p]),
      .mode_spq(port_ctl_r[p][BIT_SPQ]),
      .deq_ready(tx_ready[p]),
      .deq_valid(tx_valid[p]),
      .deq_token(tx_token[p]),
      .nonempty(q_ne[p])
    );
  end
endmodule

// *** dv/vlan_qos_egress_chk.sv ***
// checker: apb answer timing and stream hand-off of the egress block
// assumes one wait state and a master that releases after pready
`timescale 1ns/1ps
module vlan_qos_egress_chk import vlan_qos_pkg::*; #(
  parameter int NPORTS = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // streams
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_last,
  input wire logic [NPORTS-1:0] tx_ready,
  input wire logic [NPORTS-1:0] tx_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wait_s;
    psel && penable && !pready;
  endsequence
  sequence ans_s;
    psel && penable && pready;
  endsequence
  ///////////////////////////////////////////////////////////////////
  one_wait_a: assert property (wait_s |=> ans_s)
    else $error("apb answer late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  ready_acc_a: assert property (pready |-> ans_s and $past(psel))
    else $error("pready outside access");
  setup_ans_a: assert property ($rose(psel) |-> ##[1:3] pready)
    else $error("no apb answer");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  bad_port_a: assert property (pready && paddr[11:10] >= NPORTS |-> pslverr)
    else $error("bad port accepted");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  port_default_vlan_id_ok_a: assert property (pready && paddr[9:2] == IDX_PORT_DEFAULT_VLAN_ID
    && paddr[11:10] == 2'd0 |-> !pslverr)
    else $error("port_default_vlan_id refused");
  tx_hold_a: assert property (tx_valid[0] && !tx_ready[0] |=> tx_valid[0])
    else $error("queue token lost");
  fcs_drain_a: assert property (out_valid && out_last |-> !in_ready)
    else $error("input taken in fcs drain");
endmodule

bind vlan_qos_egress vlan_qos_egress_chk #(.NPORTS(NPORTS)) u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .in_ready(in_ready), .out_valid(out_valid),
  .out_last(out_last), .tx_ready(tx_ready), .tx_valid(tx_valid));

// *** dv/fwd_mac_model.sv ***
// forwarding engine source and transmit mac sinks around the block
// assumes the bench fills frm and calls send right after a rising edge
`timescale 1ns/1ps
module fwd_mac_model import vlan_qos_pkg::*; #(
  parameter int NPORTS = 3
) (
  // clock
  input wire logic pclk,
  // frame source
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last,
  output frame_meta_t in_meta,
  input wire logic in_ready,
  // edited frame sink
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  // mac handle sinks
  output logic [NPORTS-1:0] tx_ready,
  input wire logic [NPORTS-1:0] tx_valid,
  input wire queue_token_t tx_token [NPORTS]
);
  logic [7:0] frm[$];
  logic [7:0] got[$];
  queue_token_t tok[$];
  logic slow = 1'b0;
  logic [NPORTS-1:0] mac_en = '1;
  initial
  begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
    in_meta = '0;
    out_ready = 1'b1;
    tx_ready = '1;
  end
  always @(posedge pclk)
  begin
    out_ready <= slow ? ~out_ready : 1'b1;
    tx_ready <= mac_en;
  end
  // nothing moves between the falling and the next rising edge
  always @(negedge pclk)
  begin
    if (out_valid && out_ready)
      got.push_back(out_data);
    for (int p = 0; p < NPORTS; p++)
      if (tx_valid[p] && tx_ready[p])
        tok.push_back(tx_token[p]);
  end
  task automatic send(input frame_meta_t m);
    int i;
    logic r;
    i = 0;
    in_valid <= 1'b1;
    in_meta <= m;
    for (int k = 0; k < 2000 && i < frm.size(); k++)
    begin
      in_data <= frm[i];
      in_last <= (i == frm.size() - 1);
      @(negedge pclk);
      r = in_ready;
      @(posedge pclk);
      if (r)
        i++;
    end
    in_valid <= 1'b0;
    in_last <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule

// *** dv/tb_top.sv ***
// bench: registers over apb, tag edits and queue choice per frame
// assumes fwd_mac_model drives the stream and mac sides
`timescale 1ns/1ps
module tb_top import vlan_qos_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic in_valid, in_last, in_ready, out_valid, out_last, out_ready;
  logic [7:0] in_data, out_data;
  logic [1:0] out_port;
  frame_meta_t in_meta;
  logic [2:0] tx_ready, tx_valid;
  queue_token_t tx_token [3];
  int err_total = 0;
  int n_tests = 0;
  logic [7:0] ex[$];
  vlan_qos_egress DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
    .in_meta(in_meta), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_port(out_port),
    .out_ready(out_ready), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_token(tx_token));
  fwd_mac_model fw (.pclk(pclk), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_meta(in_meta), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_token(tx_token));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ///////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a,
    input logic [7:0] d, output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (!pready && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50)
    begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic wait_for(input int nb, input int nt);
    int k;
    for (k = 0; k < 500; k++)
    begin
      if (fw.got.size() >= nb && fw.tok.size() >= nt)
        break;
      @(posedge pclk);
    end
    if (k >= 500)
    begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic mk(input logic tg, input logic [7:0] pcp,
    input logic [7:0] tos);
    fw.frm.delete();
    for (int i = 0; i < 12; i++)
      fw.frm.push_back(8'(i + 1));
    if (tg)
      fw.frm = {fw.frm, 8'h81, 8'h00, pcp, 8'h05};
    fw.frm = {fw.frm, 8'h08, 8'h00, 8'h45, tos, 8'h3c, 8'h3c, 8'h3c,
      8'h3c, 8'h11, 8'h22, 8'h33, 8'h44};
  endtask
  // ed: 0 unchanged, 1 tag inserted, 2 tag removed
  task automatic run(input logic [1:0] s, input logic [1:0] d,
    input int ed, input logic [7:0] pv);
    logic [31:0] c;
    ex = fw.frm;
    if (ed == 1)
      ex = {ex[0:11], 8'h81, 8'h00, 8'h00, pv, ex[12:$]};
    if (ed == 2)
      ex = {ex[0:11], ex[16:$]};
    if (ed != 0)
    begin
      c = CRC_INIT;
      for (int i = 0; i < ex.size() - 4; i++)
      begin
        c = c ^ {24'h000000, ex[i]};
        repeat (8)
          c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      c = ~c;
      for (int j = 0; j < 4; j++)
        ex[ex.size() - 4 + j] = c[8*j +: 8];
    end
    fw.got.delete();
    fw.tok.delete();
    fw.send({s, d, 8'h5a});
    wait_for(ex.size(), fw.mac_en[d] ? 1 : 0);
    chk(out_port, d);
    chk(fw.got.size(), ex.size());
    foreach (ex[i])
      chk(fw.got[i], ex[i]);
    $display("test done: frame %0d to %0d edit %0d", s, d, ed);
  endtask
  ///////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc({2'd0, IDX_GLOBAL}, 32'(RST_GLOBAL), 1'b0);
    rdc({2'd2, IDX_PORT_CTL}, 32'(RST_PORT_CTL), 1'b0);
    rdc({2'd1, IDX_PORT_DEFAULT_VLAN_ID}, 32'(RST_PORT_DEFAULT_VLAN_ID), 1'b0);
    rdc({2'd0, IDX_TAG_MAP}, 32'(RST_TAG_MAP0), 1'b0);
    rdc({2'd0, IDX_TAG_MAP + 8'h01}, 32'(RST_TAG_MAP1), 1'b0);
    rdc({2'd0, 8'h00}, 32'h0, 1'b1);
    rdc({2'd3, IDX_PORT_DEFAULT_VLAN_ID}, 32'h0, 1'b1);
    $display("test done: register reset and refusal");
    wr({2'd1, IDX_PORT_CTL}, 8'h80);
    wr({2'd0, IDX_PORT_CTL}, 8'h02);
    wr({2'd0, IDX_PORT_DEFAULT_VLAN_ID}, 8'h2a);
    rdc({2'd0, IDX_PORT_DEFAULT_VLAN_ID}, 32'h2a, 1'b0);
    mk(1'b0, 8'h00, 8'h00);
    run(2'd0, 2'd1, 0, 8'h00);
    chk(fw.tok[0].queue, 2'd2);
    wr({2'd0, IDX_GLOBAL}, 8'h02);
    run(2'd0, 2'd1, 1, 8'h2a);
    mk(1'b1, 8'he0, 8'h00);
    fw.slow <= 1'b1;
    run(2'd0, 2'd2, 2, 8'h00);
    chk(fw.tok[0].queue, 2'd3);
    fw.slow <= 1'b0;
    wr({2'd0, IDX_PORT_CTL}, 8'h06);
    run(2'd0, 2'd1, 0, 8'h00);
    chk(fw.tok[0].queue, 2'd2);
    wr({2'd0, IDX_QOS_EN}, 8'h01);
    wr({2'd0, IDX_TOS_MAP + 8'h0f}, 8'h40);
    wr({2'd0, IDX_TOS_MAP + 8'h01}, 8'hc0);
    mk(1'b0, 8'h00, 8'hfc);
    run(2'd1, 2'd0, 0, 8'h00);
    chk(fw.tok[0].queue, 2'd1);
    wr({2'd0, IDX_GLOBAL}, 8'h82);
    run(2'd1, 2'd0, 0, 8'h00);
    chk(fw.tok[0].queue, 2'd3);
    mk(1'b1, 8'h00, 8'hfc);
    run(2'd1, 2'd1, 0, 8'h00);
    chk(fw.tok[0].queue, 2'd3);
    wr({2'd0, IDX_PORT_CTL}, 8'h20);
    fw.mac_en <= 3'b110;
    mk(1'b0, 8'h00, 8'h00);
    run(2'd1, 2'd0, 0, 8'h00);
    mk(1'b0, 8'h00, 8'hfc);
    run(2'd1, 2'd0, 0, 8'h00);
    rdc({2'd0, IDX_QLEVEL}, 32'h09, 1'b0);
    rdc({2'd0, IDX_STATUS}, 32'h06, 1'b0);
    fw.mac_en <= 3'b111;
    wait_for(0, 2);
    chk(fw.tok[0].queue, 2'd3);
    chk(fw.tok[1].queue, 2'd0);
    $display("test done: strict priority order");
    stop_test();
  end
endmodule
